// ### pkg/tip_consts.vh
`ifndef TIP_CONSTS_VH
`define TIP_CONSTS_VH
// register byte offsets on the wishbone bus
`define TIP_ADDR_CTRL      8'h00
`define TIP_ADDR_MODE      8'h04
`define TIP_ADDR_PERIOD    8'h08
`define TIP_ADDR_PERBUF    8'h0C
`define TIP_ADDR_CMP0      8'h10
`define TIP_ADDR_BUF0      8'h1C
`define TIP_ADDR_DEADTIME  8'h34
`define TIP_ADDR_IRQSTAT   8'h38
`define TIP_ADDR_IRQMASK   8'h3C
// control register fields
`define TIP_CTRL_CE        7
`define TIP_CTRL_CKS_LO    3
`define TIP_CTRL_DIV_LO    0
// mode register fields
`define TIP_MODE_OEF       4
`define TIP_MODE_ALV       3
// interrupt status bits
`define TIP_IRQ_UDF        0
`define TIP_IRQ_STOP       1
// reset values
`define TIP_CTRL_RST       8'h00
`define TIP_MODE_RST       8'h00
`define TIP_CMP_RST        10'h000
`define TIP_DT_RST         8'h00
`define TIP_IRQ_RST        2'h0
// clock select codes
`define TIP_CKS_MAX        3'h5
`endif

// ### src/tip_clock_divider.v
`include "tip_consts.vh"
`default_nettype none
module tip_clock_divider (
	input  wire       clock,
	input  wire       rstn,
	input  wire       enable,
	input  wire [2:0] select,
	output reg        tick
);
	reg [4:0] divCnt_reg;

	function [4:0] divMask;
		input [2:0] sel;
		begin
			if (sel > `TIP_CKS_MAX) begin
				divMask = 5'h1F;
			end else begin
				divMask = (5'h01 << sel) - 5'h01;
			end
		end
	endfunction

	// one-cycle pulse every 2**select system clocks, every 32 clocks for select above 5
	always @(posedge clock) begin
		if (!rstn || !enable) begin
			divCnt_reg <= 5'h00;
			tick       <= 1'b0;
		end else begin
			tick <= ((divCnt_reg & divMask(select)) == divMask(select));
			if ((divCnt_reg & divMask(select)) == divMask(select)) begin
				divCnt_reg <= 5'h00;
			end else begin
				divCnt_reg <= divCnt_reg + 5'h01;
			end
		end
	end
endmodule // tip_clock_divider
`default_nettype wire

// ### src/tip_dead_time.v
`default_nettype none
module tip_dead_time #(
	parameter DW = 8
) (
	input  wire          clock,
	input  wire          rstn,
	input  wire          enable,
	input  wire          rawPhase,
	input  wire [DW-1:0] reload,
	output wire          posActive,
	output wire          negActive
);
	reg          level_reg;
	reg          busy_reg;
	reg [DW-1:0] dtCnt_reg;

	// every change of the raw phase blanks both sides for reload+1 clocks
	always @(posedge clock) begin
		if (!rstn || !enable) begin
			level_reg <= 1'b0;
			busy_reg  <= 1'b1;
			dtCnt_reg <= {DW{1'b0}};
		end else if (rawPhase != level_reg) begin
			level_reg <= rawPhase;
			busy_reg  <= 1'b1;
			dtCnt_reg <= reload;
		end else if (busy_reg) begin
			if (dtCnt_reg == {DW{1'b0}}) begin
				busy_reg <= 1'b0;
			end else begin
				dtCnt_reg <= dtCnt_reg - {{(DW-1){1'b0}}, 1'b1};
			end
		end
	end

	// a raw pulse shorter than the dead time never reaches an output
	assign posActive = !busy_reg && level_reg;
	assign negActive = !busy_reg && !level_reg;
endmodule // tip_dead_time
`default_nettype wire

// ### src/tip_inverter_pwm.v
`include "tip_consts.vh"
`default_nettype none
module tip_inverter_pwm #(
	parameter W  = 10,
	parameter DW = 8
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        forcedStopInput,
	output reg  [5:0]  phaseOutputs,
	output reg  [5:0]  phaseOutputsOe,
	output reg         underflowInterrupt
);
	localparam [7:0] MODE_RESET = `TIP_MODE_RST;
	reg  [7:0]    inverterControl_reg;
	reg           outputActiveLevel_reg;
	reg           outputEnableFlag_reg;
	reg  [W-1:0]  periodCompare_reg;
	reg  [W-1:0]  periodBuffer_reg;
	reg  [W-1:0]  phaseCompare_reg [0:2];
	reg  [W-1:0]  compareBuffers_reg [0:5];
	reg  [DW-1:0] deadTimeReload_reg;
	reg  [1:0]    irqStatus_reg;
	reg  [1:0]    irqMask_reg;
	reg  [W-1:0]  updownCounter_reg;
	reg           countUp_reg;
	reg  [W-1:0]  activePeriod_reg;
	reg  [W-1:0]  cmpUp_reg [0:2];
	reg  [W-1:0]  cmpDown_reg [0:2];
	reg           underflow_reg;
	reg  [2:0]    irqDivCnt_reg;
	reg           irqEvent_reg;
	reg           stopSync1_reg;
	reg           stopSync2_reg;
	reg           stopPrev_reg;
	reg           cePrev_reg;
	wire          countEnable;
	wire [2:0]    countClockSelect;
	wire [2:0]    underflowIrqDivider;
	wire          countTick;
	wire          wbWrite;
	wire          wbRead;
	wire          stopEdge;
	wire [2:0]    rawPhase;
	wire [2:0]    posActive;
	wire [2:0]    negActive;
	wire [1:0]    irqSet;
	wire [1:0]    irqClear;
	wire [31:0]   ctrlMerged;
	integer       i;

	assign countEnable         = inverterControl_reg[`TIP_CTRL_CE];
	assign countClockSelect    = inverterControl_reg[`TIP_CTRL_CKS_LO+2:`TIP_CTRL_CKS_LO];
	assign underflowIrqDivider = inverterControl_reg[`TIP_CTRL_DIV_LO+2:`TIP_CTRL_DIV_LO];
	assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign wbRead  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

	// byte-lane merge of a write into a 32-bit view of a register
	function [31:0] laneMerge;
		input [31:0] oldVal;
		input [31:0] newVal;
		input [3:0]  sel;
		integer      b;
		begin
			laneMerge = oldVal;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					laneMerge[8*b +: 8] = newVal[8*b +: 8];
				end
			end
		end
	endfunction

	// zero-extends a compare value to a bus word
	function [31:0] widen;
		input [W-1:0] v;
		begin
			widen = {{(32-W){1'b0}}, v};
		end
	endfunction

	// byte-lane merge of a write into a W-bit compare register
	function [W-1:0] mergeCompare;
		input [W-1:0] oldVal;
		input [31:0]  newVal;
		input [3:0]   sel;
		reg   [31:0]  merged;
		begin
			merged       = laneMerge(widen(oldVal), newVal, sel);
			mergeCompare = merged[W-1:0];
		end
	endfunction

	assign ctrlMerged = laneMerge({24'h000000, inverterControl_reg}, wb_dat_i, wb_sel_i);

	// wishbone slave: one wait state, ack for one cycle
	always @(posedge clock) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// register writes
	always @(posedge clock) begin
		if (!rstn) begin
			inverterControl_reg   <= `TIP_CTRL_RST;
			outputActiveLevel_reg <= MODE_RESET[`TIP_MODE_ALV];
			periodCompare_reg     <= `TIP_CMP_RST;
			periodBuffer_reg      <= `TIP_CMP_RST;
			deadTimeReload_reg    <= `TIP_DT_RST;
			irqMask_reg           <= `TIP_IRQ_RST;
			for (i = 0; i < 3; i = i + 1) begin
				phaseCompare_reg[i] <= `TIP_CMP_RST;
			end
			for (i = 0; i < 6; i = i + 1) begin
				compareBuffers_reg[i] <= `TIP_CMP_RST;
			end
		end else if (wbWrite) begin
			case (wb_adr_i)
			`TIP_ADDR_CTRL: begin
				inverterControl_reg <= ctrlMerged[7:0] & 8'hBF;
			end
			`TIP_ADDR_MODE: begin
				if (wb_sel_i[0]) begin
					outputActiveLevel_reg <= wb_dat_i[`TIP_MODE_ALV];
				end
			end
			`TIP_ADDR_PERIOD: begin
				periodCompare_reg <= mergeCompare(periodCompare_reg, wb_dat_i, wb_sel_i);
			end
			`TIP_ADDR_PERBUF: begin
				periodBuffer_reg <= mergeCompare(periodBuffer_reg, wb_dat_i, wb_sel_i);
			end
			`TIP_ADDR_DEADTIME: begin
				if (wb_sel_i[0]) begin
					deadTimeReload_reg <= wb_dat_i[DW-1:0];
				end
			end
			`TIP_ADDR_IRQMASK: begin
				if (wb_sel_i[0]) begin
					irqMask_reg <= wb_dat_i[1:0];
				end
			end
			default: begin
				for (i = 0; i < 3; i = i + 1) begin
					if (wb_adr_i == `TIP_ADDR_CMP0 + 8'h04 * i[7:0]) begin
						phaseCompare_reg[i] <= mergeCompare(phaseCompare_reg[i],
							wb_dat_i, wb_sel_i);
					end
				end
				for (i = 0; i < 6; i = i + 1) begin
					if (wb_adr_i == `TIP_ADDR_BUF0 + 8'h04 * i[7:0]) begin
						compareBuffers_reg[i] <= mergeCompare(compareBuffers_reg[i],
							wb_dat_i, wb_sel_i);
					end
				end
			end
			endcase
		end
	end

	// register reads, unmapped offsets read zero
	always @(posedge clock) begin
		if (!rstn) begin
			wb_dat_o <= 32'h00000000;
		end else if (wbRead) begin
			case (wb_adr_i)
			`TIP_ADDR_CTRL:     wb_dat_o <= {24'h000000, inverterControl_reg};
			`TIP_ADDR_MODE:     wb_dat_o <= {27'h0, outputEnableFlag_reg,
				outputActiveLevel_reg, 3'h0};
			`TIP_ADDR_PERIOD:   wb_dat_o <= widen(periodCompare_reg);
			`TIP_ADDR_PERBUF:   wb_dat_o <= widen(periodBuffer_reg);
			`TIP_ADDR_CMP0:     wb_dat_o <= widen(phaseCompare_reg[0]);
			8'h14:              wb_dat_o <= widen(phaseCompare_reg[1]);
			8'h18:              wb_dat_o <= widen(phaseCompare_reg[2]);
			`TIP_ADDR_BUF0:     wb_dat_o <= widen(compareBuffers_reg[0]);
			8'h20:              wb_dat_o <= widen(compareBuffers_reg[1]);
			8'h24:              wb_dat_o <= widen(compareBuffers_reg[2]);
			8'h28:              wb_dat_o <= widen(compareBuffers_reg[3]);
			8'h2C:              wb_dat_o <= widen(compareBuffers_reg[4]);
			8'h30:              wb_dat_o <= widen(compareBuffers_reg[5]);
			`TIP_ADDR_DEADTIME: wb_dat_o <= {{(32-DW){1'b0}}, deadTimeReload_reg};
			`TIP_ADDR_IRQSTAT:  wb_dat_o <= {30'h0, irqStatus_reg};
			`TIP_ADDR_IRQMASK:  wb_dat_o <= {30'h0, irqMask_reg};
			default:            wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// count clock prescaler, held cleared while counting is off
	tip_clock_divider u_clock_divider (
		.clock  (clock),
		.rstn   (rstn),
		.enable (countEnable),
		.select (countClockSelect),
		.tick   (countTick)
	);

	// triangular up/down counter with buffer transfer at underflow
	always @(posedge clock) begin
		if (!rstn || !countEnable) begin
			updownCounter_reg <= {W{1'b0}};
			countUp_reg       <= 1'b1;
			underflow_reg     <= 1'b0;
			activePeriod_reg  <= periodCompare_reg;
			for (i = 0; i < 3; i = i + 1) begin
				cmpUp_reg[i]   <= phaseCompare_reg[i];
				cmpDown_reg[i] <= phaseCompare_reg[i];
			end
		end else if (countTick) begin
			underflow_reg <= 1'b0;
			if (countUp_reg) begin
				if (updownCounter_reg >= activePeriod_reg) begin
					if (activePeriod_reg == {W{1'b0}}) begin
						underflow_reg    <= 1'b1;
						activePeriod_reg <= periodBuffer_reg;
					end else begin
						countUp_reg       <= 1'b0;
						updownCounter_reg <= updownCounter_reg - {{(W-1){1'b0}}, 1'b1};
					end
				end else begin
					updownCounter_reg <= updownCounter_reg + {{(W-1){1'b0}}, 1'b1};
				end
			end else begin
				updownCounter_reg <= updownCounter_reg - {{(W-1){1'b0}}, 1'b1};
				if (updownCounter_reg == {{(W-1){1'b0}}, 1'b1}) begin
					countUp_reg      <= 1'b1;
					underflow_reg    <= 1'b1;
					activePeriod_reg <= periodBuffer_reg;
					for (i = 0; i < 3; i = i + 1) begin
						cmpUp_reg[i]   <= compareBuffers_reg[i];
						cmpDown_reg[i] <= compareBuffers_reg[i+3];
					end
				end
			end
		end else begin
			underflow_reg <= 1'b0;
		end
	end

	// raw phase: positive side on for period minus compare ticks in each half
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_phase
			assign rawPhase[g] = countUp_reg ?
				((updownCounter_reg > cmpUp_reg[g]) || (cmpUp_reg[g] == {W{1'b0}})) :
				(updownCounter_reg >= cmpDown_reg[g]);
			tip_dead_time #(
				.DW (DW)
			) u_dead_time (
				.clock     (clock),
				.rstn      (rstn),
				.enable    (countEnable),
				.rawPhase  (rawPhase[g]),
				.reload    (deadTimeReload_reg),
				.posActive (posActive[g]),
				.negActive (negActive[g])
			);
		end
	endgenerate

	// underflow interrupt divider
	always @(posedge clock) begin
		if (!rstn || !countEnable) begin
			irqDivCnt_reg <= 3'h0;
			irqEvent_reg  <= 1'b0;
		end else if (underflow_reg) begin
			if (irqDivCnt_reg >= underflowIrqDivider) begin
				irqDivCnt_reg <= 3'h0;
				irqEvent_reg  <= 1'b1;
			end else begin
				irqDivCnt_reg <= irqDivCnt_reg + 3'h1;
				irqEvent_reg  <= 1'b0;
			end
		end else begin
			irqEvent_reg <= 1'b0;
		end
	end

	// forced stop pin synchroniser and edge detect
	always @(posedge clock) begin
		if (!rstn) begin
			stopSync1_reg <= 1'b0;
			stopSync2_reg <= 1'b0;
			stopPrev_reg  <= 1'b0;
			cePrev_reg    <= 1'b0;
		end else begin
			stopSync1_reg <= forcedStopInput;
			stopSync2_reg <= stopSync1_reg;
			stopPrev_reg  <= stopSync2_reg;
			cePrev_reg    <= countEnable;
		end
	end
	assign stopEdge = stopSync2_reg && !stopPrev_reg;

	// output enable flag: set at start, cleared by stop or forced stop
	always @(posedge clock) begin
		if (!rstn || !countEnable) begin
			outputEnableFlag_reg <= 1'b0;
		end else if (stopEdge) begin
			outputEnableFlag_reg <= 1'b0;
		end else if (!cePrev_reg) begin
			outputEnableFlag_reg <= 1'b1;
		end
	end

	// pin drivers with selectable active level
	always @(posedge clock) begin
		if (!rstn) begin
			phaseOutputs   <= 6'h00;
			phaseOutputsOe <= 6'h00;
		end else begin
			for (i = 0; i < 3; i = i + 1) begin
				phaseOutputs[2*i]   <= posActive[i] ~^ outputActiveLevel_reg;
				phaseOutputs[2*i+1] <= negActive[i] ~^ outputActiveLevel_reg;
			end
			phaseOutputsOe <= {6{outputEnableFlag_reg && countEnable}};
		end
	end

	// sticky interrupt status, write one to clear, set wins
	assign irqSet   = {stopEdge && countEnable, irqEvent_reg};
	assign irqClear = (wbWrite && wb_adr_i == `TIP_ADDR_IRQSTAT && wb_sel_i[0]) ?
		wb_dat_i[1:0] : 2'h0;
	always @(posedge clock) begin
		if (!rstn) begin
			irqStatus_reg      <= `TIP_IRQ_RST;
			underflowInterrupt <= 1'b0;
		end else begin
			irqStatus_reg      <= (irqStatus_reg & ~irqClear) | irqSet;
			underflowInterrupt <= |(irqStatus_reg & irqMask_reg);
		end
	end
endmodule // tip_inverter_pwm
`default_nettype wire

// ### bench/tip_gate_driver_model.sv
`default_nettype none
module tip_gate_driver_model (
	input  wire logic [5:0] phaseOutputs,
	input  wire logic [5:0] phaseOutputsOe,
	output logic      [5:0] gateLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// released gate inputs fall to their pull-down
	assign gateLevel = phaseOutputs & phaseOutputsOe;
endmodule // tip_gate_driver_model
`default_nettype wire

// ### bench/tip_inverter_pwm_sva.sv
`include "tip_consts.vh"
`default_nettype none
module tip_inverter_pwm_sva #(
	parameter W  = 10,
	parameter DW = 8
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        forcedStopInput,
	input wire logic [5:0]  phaseOutputs,
	input wire logic [5:0]  phaseOutputsOe,
	input wire logic        underflowInterrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic          alv;
	logic [DW-1:0] dt;
	logic [1:0]    mask;
	logic [8:0]    blank;
	logic          wr;
	logic [5:0]    act;
	assign wr = wb_ack_o & wb_cyc_i & wb_we_i & wb_sel_i[0];
	assign act = ~(phaseOutputs ^ {6{alv}});
	always_ff @(posedge clock) begin
		if (!rstn) begin
			alv   <= 1'h0;
			dt    <= '0;
			mask  <= 2'h0;
			blank <= 9'h000;
		end else begin
			if (wr && wb_adr_i == `TIP_ADDR_MODE) alv <= wb_dat_i[`TIP_MODE_ALV];
			if (wr && wb_adr_i == `TIP_ADDR_DEADTIME) dt <= wb_dat_i[DW-1:0];
			if (wr && wb_adr_i == `TIP_ADDR_IRQMASK) mask <= wb_dat_i[1:0];
			if (act[0] | act[1]) blank <= 9'h000;
			else if (blank != 9'h1FF) blank <= blank + 9'h001;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	sequence s_ctrl_wr;
		wr && wb_adr_i == `TIP_ADDR_CTRL;
	endsequence
	property p_ack;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	property p_start;
		s_ctrl_wr ##0 (wb_dat_i[`TIP_CTRL_CE] && phaseOutputsOe == 6'h00 && !forcedStopInput)
			|-> ##[1:4] phaseOutputsOe == 6'h3F;
	endproperty
	property p_stop;
		s_ctrl_wr ##0 !wb_dat_i[`TIP_CTRL_CE] |-> ##[1:3] phaseOutputsOe == 6'h00;
	endproperty
	property p_same;
		phaseOutputsOe == 6'h00 || phaseOutputsOe == 6'h3F;
	endproperty
	property p_force;
		$rose(forcedStopInput) && phaseOutputsOe == 6'h3F |-> ##[1:6] phaseOutputsOe == 6'h00;
	endproperty
	property p_dead;
		($rose(act[0]) || $rose(act[1])) && $past(phaseOutputsOe[0], 2) && phaseOutputsOe[0]
			|-> blank >= {1'h0, dt} + 9'h001;
	endproperty
	property p_irq_mask;
		underflowInterrupt |-> (mask | $past(mask)) != 2'h0;
	endproperty
	property p_irq_fall;
		$fell(underflowInterrupt) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
	a_start: assert property (p_start) else $error("outputs not enabled");
	a_stop: assert property (p_stop) else $error("outputs not released");
	a_same: assert property (p_same) else $error("output enables differ");
	a_force: assert property (p_force) else $error("forced stop ignored");
	a_dead: assert property (p_dead) else $error("dead time too short");
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
endmodule // tip_inverter_pwm_sva
bind tip_inverter_pwm tip_inverter_pwm_sva #(.W(W), .DW(DW)) u_sva (
	.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .forcedStopInput(forcedStopInput),
	.phaseOutputs(phaseOutputs), .phaseOutputsOe(phaseOutputsOe),
	.underflowInterrupt(underflowInterrupt)
);
`default_nettype wire

// ### bench/tip_inverter_pwm_test.sv
`include "tip_consts.vh"
`default_nettype none
module tip_inverter_pwm_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'h0;
	logic        rstn = 1'h0;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic        forcedStop = 1'h0;
	logic [31:0] rdat;
	logic [31:0] rd;
	logic        ack;
	logic        irq;
	logic [5:0]  pins;
	logic [5:0]  oe;
	logic [5:0]  gate;
	integer      num_errors = 0;
	integer      n_tests = 0;
	integer      cycles = 0;
	integer      t0;
	integer      t1;
	integer      j;
	logic [2:0]  cksTab [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h0, 3'h0};
	logic [2:0]  divTab [6] = '{3'h0, 3'h7, 3'h3, 3'h1, 3'h2, 3'h5};
	logic        alvTab [6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
	logic [9:0]  cmpTab [6] = '{10'h3, 10'h3, 10'h3, 10'h3, 10'h0, 10'h9};
	tip_inverter_pwm #(.W(10), .DW(8)) dut_u (
		.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.forcedStopInput(forcedStop), .phaseOutputs(pins), .phaseOutputsOe(oe),
		.underflowInterrupt(irq)
	);
	tip_gate_driver_model gate_u (.phaseOutputs(pins), .phaseOutputsOe(oe), .gateLevel(gate));
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors = num_errors + 1;
			final_report();
		end
	end
	task automatic final_report;
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		check(ack, 1'h0);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		while (ack !== 1'h1) @(posedge clock);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic irqEdge(output integer t);
		integer i;
		for (i = 0; i < 5000 && irq !== 1'h0; i++) @(posedge clock);
		for (i = 0; i < 5000 && irq !== 1'h1; i++) @(posedge clock);
		t = cycles;
	endtask
	task automatic run(input logic [2:0] cks, input logic [2:0] dv, input logic a,
		input logic [9:0] c);
		integer i;
		integer p;
		integer q;
		integer k;
		integer n;
		integer ep;
		integer en;
		p = 0;
		q = 0;
		n = c;
		k = 1 << cks;
		wb(1'h1, `TIP_ADDR_MODE, {28'h0, a, 3'h0});
		for (i = 0; i < 3; i++) wb(1'h1, `TIP_ADDR_CMP0 + 8'(4 * i), {22'h0, c});
		for (i = 0; i < 6; i++) wb(1'h1, `TIP_ADDR_BUF0 + 8'(4 * i), {22'h0, c});
		wb(1'h1, `TIP_ADDR_CTRL, {24'h0, 1'h1, 1'h0, cks, dv});
		repeat (48 * k) @(posedge clock);
		check(oe, 6'h3F);
		rdchk(`TIP_ADDR_MODE, {27'h0, 1'h1, a, 3'h0});
		repeat (64 * k) begin
			@(posedge clock);
			p += (gate[0] === a) + (gate[2] === a) + (gate[4] === a);
			q += (gate[1] === a) + (gate[3] === a) + (gate[5] === a);
		end
		ep = (n > 8) ? 0 : (16 - 2 * n) * k - 2;
		en = (n > 8) ? 16 * k : 2 * n * k - 2;
		if (en < 0) en = 0;
		if (n != 0) check(p, 12 * ep);
		check(q, 12 * en);
		wb(1'h1, `TIP_ADDR_IRQSTAT, 32'h3);
		irqEdge(t0);
		wb(1'h1, `TIP_ADDR_IRQSTAT, 32'h1);
		irqEdge(t1);
		check(t1 - t0, (dv + 1) * 16 * k);
		wb(1'h1, `TIP_ADDR_CTRL, {26'h0, cks, dv});
		repeat (4) @(posedge clock);
		check(oe, 6'h00);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rstn <= 1'h1;
		check(oe, 6'h00);
		rdchk(`TIP_ADDR_CTRL, 32'h0);
		wb(1'h1, `TIP_ADDR_CTRL, 32'h7F);
		rdchk(`TIP_ADDR_CTRL, 32'h3F);
		wb(1'h1, 8'h40, 32'h5A);
		rdchk(8'h40, 32'h0);
		wb(1'h1, `TIP_ADDR_MODE, 32'h1F);
		rdchk(`TIP_ADDR_MODE, 32'h08);
		wb(1'h1, `TIP_ADDR_PERIOD, 32'h8);
		wb(1'h1, `TIP_ADDR_PERBUF, 32'h8);
		wb(1'h1, `TIP_ADDR_DEADTIME, 32'h1);
		wb(1'h1, `TIP_ADDR_IRQMASK, 32'h1);
		for (j = 0; j < 6; j++) run(cksTab[j], divTab[j], alvTab[j], cmpTab[j]);
		wb(1'h1, `TIP_ADDR_CTRL, 32'h80);
		wb(1'h1, `TIP_ADDR_IRQMASK, 32'h0);
		repeat (8) @(posedge clock);
		forcedStop <= 1'h1;
		repeat (8) @(posedge clock);
		check(oe, 6'h00);
		wb(1'h0, `TIP_ADDR_MODE, 32'h0);
		check(rd[4], 1'h0);
		wb(1'h0, `TIP_ADDR_IRQSTAT, 32'h0);
		check(rd[1:0], 2'h3);
		check(irq, 1'h0);
		forcedStop <= 1'h0;
		wb(1'h1, `TIP_ADDR_CTRL, 32'h00);
		final_report();
	end
endmodule // tip_inverter_pwm_test
`default_nettype wire
